// [inc/rac_pkg.sv]
/*
  constants for the rtc calendar, alarm and control block.
  assumes a 125 MHz system clock.
*/
// ==========================================
// Summary of operation
// - timeout before acknowledge discards the byte
// - time registers hold and count BCD
// - weekday advances at midnight, 7 wraps 1
// - century bit toggles on year 99 to 00
// - hours bit6 12h mode, bit5 pm/tens
// - reset time 00:00:00 01/01/00, weekday 01
// - alarm bit7 masks, all zero full match
// - day/date select bit picks compare target
// - alarm one mask rates per second upward
// - alarm two mask rates per minute upward
// - match sets flag, enabled drives routed pin
// - flag sets regardless of enable, enables reset
// - control bit7 stops oscillator, reset clear
// - control bit5 enables 5us glitch filter
// - rate select picks square frequency, reset 11
// - fast squares and 1Hz alike are divider taps, same filter
// - 1Hz square may jitter up to 2ms
// - steering 0 puts square on pin b
// - steering 1, no reference: split alarm pins
// - steering 1, reference: both alarms pin b
// - steering bit cleared at reset
// - pin low while routed flag and enable
// - flags clear only on written zero
// - reference enable status bit2, reset clear
package rac_pkg;
  // ==========================================
  // register offsets
  localparam logic [3:0] RAC_SEC   = 4'h0;
  localparam logic [3:0] RAC_MIN   = 4'h1;
  localparam logic [3:0] RAC_HOUR  = 4'h2;
  localparam logic [3:0] RAC_WDAY  = 4'h3;
  localparam logic [3:0] RAC_DATE  = 4'h4;
  localparam logic [3:0] RAC_MONTH = 4'h5;
  localparam logic [3:0] RAC_YEAR  = 4'h6;
  localparam logic [3:0] RAC_ALM0  = 4'h7;
  localparam logic [3:0] RAC_CTRL  = 4'hE;
  localparam logic [3:0] RAC_STAT  = 4'hF;
  // writable bits per offset
  localparam logic [15:0][7:0] RAC_WMASK = {
    8'h07, 8'hBF, {7{8'hFF}}, 8'hFF, 8'h9F,
    8'h3F, 8'h07, 8'h7F, 8'h7F, 8'h7F};
  // ==========================================
  // field positions
  localparam int RAC_MASK_BIT = 7;
  localparam int RAC_DYDT_BIT = 6;
  localparam int RAC_H12_BIT  = 6;
  localparam int RAC_PM_BIT   = 5;
  localparam int RAC_CENTURY_TOGGLE_BIT_BIT = 7;
  localparam int RAC_OSCD_BIT = 7;
  localparam int RAC_FILT_BIT = 5;
  localparam int RAC_RS_LO    = 3;
  localparam int RAC_STEER_BIT = 2;
  localparam int RAC_ALARM_TWO_IRQ_ENABLE_BIT = 1;
  localparam int RAC_ALARM_ONE_IRQ_ENABLE_BIT = 0;
  localparam int RAC_EXT_REFERENCE_ENABLE_BIT = 2;
  localparam int RAC_A2F_BIT  = 1;
  localparam int RAC_A1F_BIT  = 0;
  // ==========================================
  // reset values
  localparam logic [7:0] RAC_CTRL_RST = 8'h18;
  localparam logic [7:0] RAC_ZERO_RST = 8'h00;
  localparam logic [7:0] RAC_ONE_RST  = 8'h01;
  // ==========================================
  // timing
  localparam int RAC_CLK_NS  = 8;
  localparam int RAC_FILT_NS = 5000;
  localparam int RAC_FILT_CYC =
    (RAC_FILT_NS + RAC_CLK_NS - 1) / RAC_CLK_NS;
  localparam int RAC_DIV_BITS = 16;
endpackage

// [inc/rac_osc_if.sv]
/*
  carrier between control logic and oscillator divider.
  osc_disable is a system-clock level; taps are
  oscillator-clock flops, synchronised by the reader.
*/
`timescale 1ns/10ps
interface rac_osc_if;
  logic       osc_disable;
  logic [3:0] taps;
  modport ctl (output osc_disable, input taps);
  modport osc (input osc_disable, output taps);
endinterface

// [rtl/rac_osc_divider.sv]
/*
  oscillator divider on the oscillator clock.
  osc_clk runs at twice 32.768 kHz; counter bit0
  is the 32.768 kHz square, top bit the 1 Hz square.
*/
`timescale 1ns/10ps
module rac_osc_divider
  import rac_pkg::*;
#(
  parameter int DIV_BITS = RAC_DIV_BITS
)
(
  input wire logic osc_clk,
  input wire logic reset_n,
  rac_osc_if.osc   osc
);
  logic [1:0]          rst_sync;
  logic [1:0]          dis_sync;
  logic [DIV_BITS-1:0] count;

  // ==========================================
  // crossings into oscillator domain
  always_ff @(posedge osc_clk)
  begin
    rst_sync <= {rst_sync[0], reset_n};
  end

  always_ff @(posedge osc_clk)
  begin
    dis_sync <= {dis_sync[0], osc.osc_disable};
  end

  // ==========================================
  // divider chain, frozen while stopped
  always_ff @(posedge osc_clk)
  begin
    if (!rst_sync[1])
      count <= '0;
    else if (!dis_sync[1])
      count <= count + 1'b1;
  end

  // taps: 1Hz, 4096Hz, 8192Hz, 32768Hz
  assign osc.taps = {count[DIV_BITS-1], count[3],
                     count[2], count[0]};
endmodule

// [rtl/rac_top.sv]
/*
  rtc clock, calendar, two alarms and control.
  registers reached by a byte port from the serial
  engine; a write commits at acknowledge time.
*/
`timescale 1ns/10ps
module rac_top
  import rac_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       osc_clk,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_wr_timeout,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       irq_a_in,
  output logic            irq_a_out,
  output logic            irq_a_oe_n,
  input  wire logic       irq_b_in,
  output logic            irq_b_out,
  output logic            irq_b_oe_n
);
  import rac_pkg::*;

  rac_osc_if osc_bus ();

  logic [7:0] sec, min, hour, wday;
  logic [7:0] date, month, year;
  logic [7:0] next_sec, next_min, next_hour;
  logic [7:0] next_wday, next_date;
  logic [7:0] next_month, next_year;
  logic [7:0] alarm [7];
  logic [7:0] ctrl;
  logic       ext_reference_enable, a1f, a2f;
  logic [3:0] tap_m, tap_s;
  logic [3:0] filt_cand, filt_q;
  logic [9:0] filt_cnt;
  logic       tick_prev, tick, eval;
  logic       commit, a1_hit, a2_hit;
  logic       a1_act, a2_act;
  logic       sqw_level;

  // ==========================================
  // oscillator divider
  rac_osc_divider #(
    .DIV_BITS (RAC_DIV_BITS)
  ) u_div (
    .osc_clk (osc_clk),
    .reset_n (reset_n),
    .osc     (osc_bus.osc)
  );

  assign osc_bus.osc_disable = ctrl[RAC_OSCD_BIT];

  // two-flop synchroniser per tap
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge clock)
    begin
      tap_m[i] <= osc_bus.taps[i];
      tap_s[i] <= tap_m[i];
    end
  end

  // ==========================================
  // glitch filter: accept only stable taps
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      filt_cand <= '0;
      filt_cnt  <= '0;
      filt_q    <= '0;
    end
    else
    begin
      filt_cand <= tap_s;
      if (tap_s != filt_cand)
        filt_cnt <= '0;
      else if (filt_cnt != 10'(RAC_FILT_CYC - 1))
        filt_cnt <= filt_cnt + 1'b1;
      if (!ctrl[RAC_FILT_BIT])
        filt_q <= tap_s;
      else if (filt_cnt == 10'(RAC_FILT_CYC - 1))
        filt_q <= filt_cand;
    end
  end

  // ==========================================
  // seconds tick from 1 Hz rising edge
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      tick_prev <= 1'b0;
      eval      <= 1'b0;
    end
    else
    begin
      tick_prev <= filt_q[3];
      eval      <= tick;
    end
  end

  assign tick = filt_q[3] & ~tick_prev;

  // square rate select
  always_comb
  begin
    case (ctrl[RAC_RS_LO +: 2])
      2'b00:   sqw_level = filt_q[3];
      2'b01:   sqw_level = filt_q[2];
      2'b10:   sqw_level = filt_q[1];
      default: sqw_level = filt_q[0];
    endcase
  end

  // ==========================================
  // BCD helpers
  function automatic logic [7:0] bcd_inc
    (input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = v + 8'h01;
  endfunction

  function automatic logic [7:0] month_len
    (input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = (~y[4] & (y[3:0] == 4'h0 ||
            y[3:0] == 4'h4 || y[3:0] == 4'h8)) |
           (y[4] & (y[3:0] == 4'h2 ||
            y[3:0] == 4'h6));
    case (m)
      8'h02:   month_len = leap ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction

  // ==========================================
  // calendar advance on each tick
  always_comb
  begin
    logic midnight;
    logic [7:0] h;
    logic [7:0] h12_inc;
    logic [7:0] h24_inc;
    logic [7:0] mon_inc;
    midnight   = 1'b0;
    h          = 8'h00;
    h12_inc    = bcd_inc({3'b000, hour[4:0]});
    h24_inc    = bcd_inc({2'b00, hour[5:0]});
    mon_inc    = bcd_inc({3'b000, month[4:0]});
    next_sec   = sec;
    next_min   = min;
    next_hour  = hour;
    next_wday  = wday;
    next_date  = date;
    next_month = month;
    next_year  = year;
    if (tick && sec != 8'h59)
      next_sec = bcd_inc(sec);
    else if (tick)
    begin
      next_sec = 8'h00;
      next_min = (min == 8'h59) ? 8'h00 : bcd_inc(min);
      if (min == 8'h59)
      begin
        if (hour[RAC_H12_BIT])
        begin
          h = {3'b000, hour[4:0]};
          if (h == 8'h12)
            next_hour = {hour[7:5], 5'h01};
          else if (h == 8'h11)
          begin
            next_hour = hour ^ 8'h23;
            midnight  = hour[RAC_PM_BIT];
          end
          else
            next_hour = {hour[7:5], h12_inc[4:0]};
        end
        else if (hour[5:0] == 6'h23)
        begin
          next_hour = {hour[7:6], 6'h00};
          midnight  = 1'b1;
        end
        else
          next_hour = {hour[7:6], h24_inc[5:0]};
      end
      if (midnight)
      begin
        next_wday = (wday == 8'h07) ? 8'h01
                                    : wday + 8'h01;
        if (date == month_len(month & 8'h1F, year))
        begin
          next_date = 8'h01;
          if (month[4:0] == 5'h12)
          begin
            next_month = {month[7:5], 5'h01};
            if (year == 8'h99)
            begin
              next_year = 8'h00;
              next_month[RAC_CENTURY_TOGGLE_BIT_BIT] =
                ~month[RAC_CENTURY_TOGGLE_BIT_BIT];
            end
            else
              next_year = bcd_inc(year);
          end
          else
            next_month = {month[7:5],
              mon_inc[4:0]};
        end
        else
          next_date = bcd_inc(date);
      end
    end
  end

  // ==========================================
  // write commits only if no timeout before ack
  assign commit = reg_wr & ~reg_wr_timeout;

  // time registers: write wins over advance
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sec   <= RAC_ZERO_RST;
      min   <= RAC_ZERO_RST;
      hour  <= RAC_ZERO_RST;
      wday  <= RAC_ONE_RST;
      date  <= RAC_ONE_RST;
      month <= RAC_ONE_RST;
      year  <= RAC_ZERO_RST;
    end
    else
    begin
      sec   <= next_sec;
      min   <= next_min;
      hour  <= next_hour;
      wday  <= next_wday;
      date  <= next_date;
      month <= next_month;
      year  <= next_year;
      if (commit)
      begin
        case (reg_addr)
          RAC_SEC:   sec   <= reg_wdata & RAC_WMASK[0];
          RAC_MIN:   min   <= reg_wdata & RAC_WMASK[1];
          RAC_HOUR:  hour  <= reg_wdata & RAC_WMASK[2];
          RAC_WDAY:  wday  <= reg_wdata & RAC_WMASK[3];
          RAC_DATE:  date  <= reg_wdata & RAC_WMASK[4];
          RAC_MONTH: month <= reg_wdata & RAC_WMASK[5];
          RAC_YEAR:  year  <= reg_wdata & RAC_WMASK[6];
          default:   ;
        endcase
      end
    end
  end

  // alarm registers, one per entry
  for (genvar k = 0; k < 7; k++)
  begin : g_alarm
    always_ff @(posedge clock)
    begin
      if (!reset_n)
        alarm[k] <= RAC_ZERO_RST;
      else if (commit && reg_addr == RAC_ALM0 + 4'(k))
        alarm[k] <= reg_wdata;
    end
  end

  // control register, bit6 held at zero
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      ctrl <= RAC_CTRL_RST;
    else if (commit && reg_addr == RAC_CTRL)
      ctrl <= reg_wdata & RAC_WMASK[14];
  end

  // ==========================================
  // alarm compare on updated counters
  always_comb
  begin
    logic [7:0] dd1, dd2;
    dd1 = alarm[3][RAC_DYDT_BIT] ? wday : date;
    dd2 = alarm[6][RAC_DYDT_BIT] ? wday : date;
    a1_hit = (alarm[0][7] | alarm[0][6:0] == sec[6:0]) &
             (alarm[1][7] | alarm[1][6:0] == min[6:0]) &
             (alarm[2][7] | alarm[2][6:0] == hour[6:0]) &
             (alarm[3][7] |
              alarm[3][5:0] == dd1[5:0]);
    a2_hit = (sec == 8'h00) &
             (alarm[4][7] | alarm[4][6:0] == min[6:0]) &
             (alarm[5][7] | alarm[5][6:0] == hour[6:0]) &
             (alarm[6][7] |
              alarm[6][5:0] == dd2[5:0]);
  end

  // flags: set wins over a written zero
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      a1f  <= 1'b0;
      a2f  <= 1'b0;
      ext_reference_enable <= 1'b0;
    end
    else
    begin
      if (eval && a1_hit)
        a1f <= 1'b1;
      else if (commit && reg_addr == RAC_STAT &&
               !reg_wdata[RAC_A1F_BIT])
        a1f <= 1'b0;
      if (eval && a2_hit)
        a2f <= 1'b1;
      else if (commit && reg_addr == RAC_STAT &&
               !reg_wdata[RAC_A2F_BIT])
        a2f <= 1'b0;
      if (commit && reg_addr == RAC_STAT)
        ext_reference_enable <= reg_wdata[RAC_EXT_REFERENCE_ENABLE_BIT];
    end
  end

  // ==========================================
  // pin steering
  assign a1_act = a1f & ctrl[RAC_ALARM_ONE_IRQ_ENABLE_BIT];
  assign a2_act = a2f & ctrl[RAC_ALARM_TWO_IRQ_ENABLE_BIT];

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      irq_a_out  <= 1'b0;
      irq_a_oe_n <= 1'b1;
      irq_b_out  <= 1'b0;
      irq_b_oe_n <= 1'b0;
    end
    else
    begin
      irq_a_out <= 1'b0;
      if (ext_reference_enable)
        irq_a_oe_n <= 1'b1;
      else if (ctrl[RAC_STEER_BIT])
        irq_a_oe_n <= ~a1_act;
      else
        irq_a_oe_n <= ~(a1_act | a2_act);
      if (!ctrl[RAC_STEER_BIT])
      begin
        irq_b_out  <= sqw_level;
        irq_b_oe_n <= 1'b0;
      end
      else
      begin
        irq_b_out  <= 1'b0;
        irq_b_oe_n <= ext_reference_enable ? ~(a1_act | a2_act)
                           : ~a2_act;
      end
    end
  end

  // register read, answer one cycle later
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        RAC_SEC:   reg_rdata <= sec;
        RAC_MIN:   reg_rdata <= min;
        RAC_HOUR:  reg_rdata <= hour;
        RAC_WDAY:  reg_rdata <= wday;
        RAC_DATE:  reg_rdata <= date;
        RAC_MONTH: reg_rdata <= month;
        RAC_YEAR:  reg_rdata <= year;
        RAC_CTRL:  reg_rdata <= ctrl;
        RAC_STAT:  reg_rdata <= {5'h00, ext_reference_enable, a2f, a1f};
        default:   reg_rdata <= alarm[3'(reg_addr - RAC_ALM0)];
      endcase
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_flag_on_match: assert property (
    eval && a1_hit |=> a1f)
    else $error("alarm one flag not set on match");
  a_flag_keep_one: assert property (
    a2f && commit && reg_addr == RAC_STAT &&
    reg_wdata[RAC_A2F_BIT] |=> a2f)
    else $error("flag cleared by written one");
  a_timeout_drop: assert property (
    reg_wr && reg_wr_timeout && !tick
    |=> $stable({ctrl, ext_reference_enable, sec, min, hour, wday, date, month, year}))
    else $error("timed out byte was written");
  a_ctrl_bit_six: assert property (
    !ctrl[6])
    else $error("control bit6 set");
  a_sec_bcd: assert property (
    tick && !commit && sec[3:0] <= 4'h9 && sec[6:4] <= 3'h5
    |=> sec[3:0] <= 4'h9 && sec[6:4] <= 3'h5)
    else $error("seconds not BCD");
  a_wday_wrap: assert property (
    tick && !commit && wday == 8'h07 &&
    next_wday != wday |=> wday == 8'h01)
    else $error("weekday did not wrap to 1");
  a_century_toggle_bit_toggle: assert property (
    tick && !commit && year == 8'h99 &&
    next_year == 8'h00
    |=> month[7] != $past(month[7]))
    else $error("century did not toggle");
  a_pin_a_split: assert property (
    ctrl[2] && !ext_reference_enable && a1_act |=> !irq_a_oe_n)
    else $error("pin a not low on alarm one");
  a_pin_b_both: assert property (
    ctrl[2] && ext_reference_enable && (a1_act || a2_act)
    |=> !irq_b_oe_n && irq_a_oe_n)
    else $error("pin b not low with reference");
  a_eval_after: assert property (
    tick |=> eval ##1 !eval)
    else $error("alarm evaluation misplaced");

  c_alarm_one: cover property (eval && a1_hit);
  c_alarm_two: cover property (eval && a2_hit);
  c_midnight:  cover property (tick && next_wday != wday);
  c_century:   cover property (tick && next_year == 8'h00 &&
                               year == 8'h99);
endmodule

// [sim/rac_host_model.sv]
/*
  byte-port host standing in for the serial engine and its master.
  assumes the block takes a request on the rising clock edge.
*/
`timescale 1ns/10ps
module rac_host_model
(
  input  wire logic       clock,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_wr_timeout,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle levels at time zero
  initial
  begin
    reg_addr       = 4'h0;
    reg_wdata      = 8'h00;
    reg_wr         = 1'b0;
    reg_wr_timeout = 1'b0;
    reg_rd         = 1'b0;
  end

  // one byte write, late marks a timeout before ack
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic late);
    @(posedge clock);
    #1;
    reg_addr       = a;
    reg_wdata      = d;
    reg_wr_timeout = late;
    reg_wr         = 1'b1;
    @(posedge clock);
    #1;
    reg_wr         = 1'b0;
    reg_wr_timeout = 1'b0;
    reg_addr       = ~a; // released lines lose old value
    reg_wdata      = ~d;
  endtask

  // one byte read, taken a cycle after the request
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clock);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    @(posedge clock);
    #1;
    d = reg_rdata;
  endtask
endmodule

// [sim/tb_rtc_calendar_alarm_control.sv]
/*
  testbench for the clock, calendar, alarm and control block.
  assumes rac_top and rac_host_model; osc clock 6 ns, free phase.
*/
`timescale 1ns/10ps
module tb_rtc_calendar_alarm_control;
  import rac_pkg::*;
  logic       clock;
  logic       reset_n;
  logic       osc_clk;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_wr_timeout;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       irq_a_out;
  logic       irq_a_oe_n;
  logic       irq_b_out;
  logic       irq_b_oe_n;
  logic       pin_a;
  logic       pin_b;
  logic [7:0] got;
  logic [7:0] d;
  logic [3:0] a;
  logic       last;
  integer     miscompares;
  integer     tests_run;
  integer     seed;
  integer     n;
  logic [7:0] exp_reg [16];
  logic [7:0] wm [16] = '{8'h7F, 8'h7F, 8'h7F, 8'h07, 8'h3F, 8'h9F, 8'hFF, 8'hFF,
                         8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'h07};
  logic [7:0] setup [16] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h00,
                            8'h00, 8'h00, 8'h41, 8'h80, 8'h80, 8'h80, 8'h05, 8'h00};

  // ==========================================
  // clocks and open-drain pin levels
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    osc_clk = 1'b0;
    #1.7;
    forever #3 osc_clk = ~osc_clk;
  end
  assign pin_a = irq_a_oe_n ? 1'b1 : irq_a_out;
  assign pin_b = irq_b_oe_n ? 1'b1 : irq_b_out;

  // ==========================================
  // design and host
  rac_top u_dut (.clock(clock), .reset_n(reset_n), .osc_clk(osc_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_wr_timeout(reg_wr_timeout), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_a_in(pin_a), .irq_a_out(irq_a_out), .irq_a_oe_n(irq_a_oe_n),
    .irq_b_in(pin_b), .irq_b_out(irq_b_out), .irq_b_oe_n(irq_b_oe_n));
  rac_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_wr_timeout(reg_wr_timeout), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // ==========================================
  // checking helpers and reference model
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic put(input logic [3:0] ad, input logic [7:0] v);
    u_host.wr(ad, v, 1'b0);
    if (ad == RAC_STAT)
      exp_reg[ad] = (v & 8'h04) | (exp_reg[ad] & v & 8'h03);
    else
      exp_reg[ad] = v & wm[ad];
  endtask
  task automatic look(input logic [3:0] ad);
    u_host.rd(ad, got);
    chk("register", exp_reg[ad], got);
  endtask
  task automatic pins(input logic ea, input logic eb);
    repeat (4) @(posedge clock);
    #1;
    chk("pin_a_oe_n", {7'h00, ea}, {7'h00, irq_a_oe_n});
    chk("pin_b_oe_n", {7'h00, eb}, {7'h00, irq_b_oe_n});
    chk("pin_a_out", 8'h00, {7'h00, irq_a_out});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog beyond the first 1 Hz tick
  initial
  begin
    #(8 * 45000);
    miscompares++;
    summarize();
  end

  // ==========================================
  // main sequence
  initial
  begin
    miscompares = 0;
    tests_run = 0;
    seed = 32'hE56D;
    reset_n = 1'b0;
    foreach (exp_reg[i])
      exp_reg[i] = (i >= 3 && i <= 5) ? 8'h01 : 8'h00;
    exp_reg[14] = 8'h18;
    repeat (4) @(posedge clock);
    #1;
    reset_n = 1'b1;
    for (int i = 0; i < 16; i++)
      look(i[3:0]);
    pins(1'b1, 1'b0);
    // random bytes everywhere, some dropped by timeout
    for (int i = 0; i < 48; i++)
    begin
      d = $random(seed);
      a = $random(seed);
      if (d[7] & d[6])
        u_host.wr(a, d, 1'b1);
      else
        put(a, d);
      look(a);
    end
    // one second before midnight, new year, weekday 7
    foreach (setup[i])
      put(i[3:0], setup[i]);
    for (n = 0; n < 35000 && irq_a_oe_n !== 1'b0; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk("alarm_pin_wait", 8'h00, {7'h00, irq_a_oe_n});
    exp_reg = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h81, 8'h00, 8'h00,
                8'h00, 8'h00, 8'h41, 8'h80, 8'h80, 8'h80, 8'h05, 8'h03};
    for (int i = 0; i < 16; i++)
      look(i[3:0]);
    pins(1'b0, 1'b1);
    put(RAC_STAT, 8'h07);
    look(RAC_STAT);
    pins(1'b1, 1'b0);
    put(RAC_STAT, 8'h06);
    pins(1'b1, 1'b1);
    put(RAC_CTRL, 8'h07);
    pins(1'b1, 1'b0);
    put(RAC_CTRL, 8'h03);
    pins(1'b1, 1'b0);
    put(RAC_STAT, 8'h02);
    pins(1'b0, 1'b0);
    put(RAC_STAT, 8'h00);
    repeat (100) @(posedge clock);
    look(RAC_STAT);
    pins(1'b1, 1'b0);
    // square rates, then a stopped oscillator
    for (int r = 0; r < 5; r++)
    begin
      put(RAC_CTRL, (r == 4) ? 8'h98 : {3'b000, r[1:0], 3'b000});
      repeat (8) @(posedge clock);
      n = 0;
      last = irq_b_out;
      repeat (64)
      begin
        @(posedge clock);
        #1;
        n += (irq_b_out !== last);
        last = irq_b_out;
      end
      chk("square_moves", {7'h00, r > 0 && r < 4}, {7'h00, n > 0});
    end
    summarize();
  end
endmodule
